// File: src/hsc_ctrl.sv
// ----------------------------------------------------------------------------
// Summary of operation
// - Stay disconnected, all pins released, at power-up.
// - After first timer, sample line pair states.
// - Valid termination starts second timer.
// - After second timer arm stop/idle detect.
// - Connect on enable plus idle or stop.
// - Enable low: disconnect and release ready.
// - Supply loss, or termination loss once armed, reruns full sequence; enable low returns to armed.
// - Plug-in detect low when lines steadily attached.
// - Ready low only when enabled, detected, connected.
// - Each node drives or receives, never both.
// - Plus above minus means released high.
// - Level decided from pair difference only.
// - Third channel behaves like clock and data.
// - Enable defaults high when not driven.
// ----------------------------------------------------------------------------
`timescale 1ns/100ps
`include "hsc_defs.svh"

module hsc_ctrl
  import hsc_pkg::*;
#(
  parameter int CLK_MHZ     = `HSC_CLK_MHZ,
  parameter int REF_CYCLES  = `HSC_T_REF_US * CLK_MHZ,
  parameter int TERM_CYCLES = `HSC_T_TERM_US * CLK_MHZ,
  parameter int IDLE_CYCLES = `HSC_IDLE_CYCLES
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      arst_n_in,
  input  wire logic                      supply_good_in,
  input  wire logic                      enable_in,
  input  wire logic                      enable_driven_in,
  input  wire logic [`HSC_NCH-1:0]       se_line_in,
  input  wire hsc_pair_type [`HSC_NCH-1:0] pair_in,
  output hsc_drive_type [`HSC_NCH-1:0]   se_drive_out,
  output hsc_drive_type [`HSC_NCH-1:0]   plus_drive_out,
  output hsc_drive_type [`HSC_NCH-1:0]   minus_drive_out,
  output logic                           plug_in_detect_n_out,
  output logic                           plug_in_detect_n_oe_out,
  output logic                           ready_n_out,
  output logic                           ready_n_oe_out
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------

  localparam int SW = 3 + `HSC_NCH + 4 * `HSC_NCH;

  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;

  // Every pin is asynchronous to the oscillator, so it passes two flops.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {supply_good_in, enable_in, enable_driven_in, se_line_in, pair_in};
      sync2 <= sync1;
    end
  end

  hsc_pair_type [`HSC_NCH-1:0] pair_s;
  logic [`HSC_NCH-1:0]         se_s;
  logic                        supply_ok;
  logic                        en_pin;
  logic                        en_driven;
  logic                        en_s;

  assign pair_s    = sync2[4*`HSC_NCH-1:0];
  assign se_s      = sync2[5*`HSC_NCH-1:4*`HSC_NCH];
  assign en_driven = sync2[SW-3];
  assign en_pin    = sync2[SW-2];
  assign supply_ok = sync2[SW-1];
  // An undriven enable pin reads as high, like an internal pull-up.
  assign en_s      = en_driven ? en_pin : 1'b1;

  // --------------------------------------------------------------------------
  // Differential receivers
  // --------------------------------------------------------------------------

  // Level taken from the comparison only, so common-mode offset is ignored.
  logic [`HSC_NCH-1:0] line_high;
  for (genvar i = 0; i < `HSC_NCH; i++) begin : g_rx
    assign line_high[i] = pair_s[i].plus_high & ~pair_s[i].minus_high;
  end

  // Valid termination on both clock and data pairs.
  logic term_ok;
  assign term_ok = pair_s[`HSC_CH_CLK].minus_below_90 & pair_s[`HSC_CH_DAT].minus_below_90
                 & pair_s[`HSC_CH_CLK].plus_above_10 & pair_s[`HSC_CH_DAT].plus_above_10;

  // --------------------------------------------------------------------------
  // Stop and idle detection
  // --------------------------------------------------------------------------

  hsc_state_type state;
  logic [31:0]   timer;
  logic [31:0]   idle_cnt;
  logic          data_q;
  logic          stop_seen;
  logic          idle_ok;
  logic          armed;

  assign armed   = (state == HSC_ARMED);
  assign idle_ok = (idle_cnt >= 32'(IDLE_CYCLES));

  // Idle counter runs while clock and data both read high on the pairs after arming.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      idle_cnt <= '0;
    end else if (!armed || !(line_high[`HSC_CH_CLK] & line_high[`HSC_CH_DAT])) begin
      idle_cnt <= '0;
    end else if (!idle_ok) begin
      idle_cnt <= idle_cnt + 32'd1;
    end
  end

  // A stop is data rising while clock stays high on the pairs.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      data_q    <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      data_q <= line_high[`HSC_CH_DAT];
      if (!armed) begin
        stop_seen <= 1'b0;
      end else if (line_high[`HSC_CH_CLK] & line_high[`HSC_CH_DAT] & ~data_q) begin
        stop_seen <= 1'b1;
      end else if (!line_high[`HSC_CH_CLK]) begin
        stop_seen <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Hot-swap sequencer
  // --------------------------------------------------------------------------

  logic connect_ok;
  logic lost;
  assign connect_ok = en_s & (idle_ok | (stop_seen & se_s[`HSC_CH_CLK] & se_s[`HSC_CH_DAT]));
  // Losing supply or termination drops back to the start of the sequence.
  assign lost = ~supply_ok | ~term_ok;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= HSC_POWERUP;
      timer <= '0;
    end else if (!supply_ok) begin
      state <= HSC_POWERUP;
      timer <= '0;
    end else begin
      case (state)
        HSC_POWERUP: begin
          state <= HSC_REF_WAIT;
          timer <= '0;
        end
        HSC_REF_WAIT: begin
          if (timer >= 32'(REF_CYCLES - 1)) begin
            state <= HSC_TERM_CHECK;
            timer <= '0;
          end else begin
            timer <= timer + 32'd1;
          end
        end
        HSC_TERM_CHECK: begin
          timer <= '0;
          if (term_ok) state <= HSC_TERM_WAIT;
        end
        HSC_TERM_WAIT: begin
          if (!term_ok) begin
            state <= HSC_TERM_CHECK;
            timer <= '0;
          end else if (timer >= 32'(TERM_CYCLES - 1)) begin
            state <= HSC_ARMED;
            timer <= '0;
          end else begin
            timer <= timer + 32'd1;
          end
        end
        HSC_ARMED: begin
          if (lost) state <= HSC_POWERUP;
          else if (connect_ok) state <= HSC_CONNECTED;
        end
        HSC_CONNECTED: begin
          // Enable low separates the sides; a later high must see idle or a stop again.
          if (lost) state <= HSC_POWERUP;
          else if (!en_s) state <= HSC_ARMED;
        end
        default: state <= HSC_POWERUP;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Channel bridging
  // --------------------------------------------------------------------------

  // Which side currently pulls each channel low; the other side only listens.
  logic [`HSC_NCH-1:0] se_owner;
  logic [`HSC_NCH-1:0] line_owner;
  logic                linked;
  assign linked = (state == HSC_CONNECTED);

  for (genvar i = 0; i < `HSC_NCH; i++) begin : g_ch
    logic [2:0] guard;
    logic       free;

    // After a release our own low still echoes back through the synchronisers
    // for a few cycles; without this guard the other side would claim that echo
    // and the low would bounce between the two sides for ever.
    assign free = (guard == '0);

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        guard <= '0;
      end else if (se_owner[i] | line_owner[i]) begin
        guard <= 3'(`HSC_TURN_GUARD);
      end else if (!free) begin
        guard <= guard - 3'h1;
      end
    end

    // Ownership goes to the side that first sees low; released when it goes high.
    // A tie goes to the single-ended side, so both sides never drive at once.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        se_owner[i]   <= 1'b0;
        line_owner[i] <= 1'b0;
      end else if (!linked) begin
        se_owner[i]   <= 1'b0;
        line_owner[i] <= 1'b0;
      end else begin
        se_owner[i]   <= se_owner[i] ? ~se_s[i] : (~se_s[i] & ~line_owner[i] & free);
        line_owner[i] <= line_owner[i] ? ~line_high[i]
                                       : (~line_high[i] & ~se_owner[i] & se_s[i] & free);
      end
    end

    // Drive outputs; all released while not linked.
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        se_drive_out[i]    <= '0;
        plus_drive_out[i]  <= '0;
        minus_drive_out[i] <= '0;
      end else begin
        // Single-ended side pulls low when the pair is owned from the line.
        se_drive_out[i]    <= '{out: 1'b0, oe: linked & line_owner[i]};
        // Reversed polarity on the pair: plus low, minus high.
        plus_drive_out[i]  <= '{out: 1'b0, oe: linked & se_owner[i]};
        minus_drive_out[i] <= '{out: 1'b1, oe: linked & se_owner[i]};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status outputs
  // --------------------------------------------------------------------------

  logic detect_low;
  // Supply loss already forces the sequencer back to the start, so detect
  // drops in the same cycle as the channel drives.
  assign detect_low = (state == HSC_ARMED) || (state == HSC_CONNECTED);

  // Open-drain status pins: enable high pulls the pin low.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      plug_in_detect_n_out    <= 1'b0;
      plug_in_detect_n_oe_out <= 1'b0;
      ready_n_out             <= 1'b0;
      ready_n_oe_out          <= 1'b0;
    end else begin
      plug_in_detect_n_out    <= 1'b0;
      plug_in_detect_n_oe_out <= detect_low;
      ready_n_out             <= 1'b0;
      ready_n_oe_out          <= en_s & detect_low & linked;
    end
  end

endmodule // hsc_ctrl

// File: src/hsc_defs.svh
`ifndef HSC_DEFS_SVH
`define HSC_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing constants
// ----------------------------------------------------------------------------

// First hot-swap delay in microseconds.
`define HSC_T_REF_US       1000
// Second hot-swap delay in microseconds.
`define HSC_T_TERM_US      10000
// Oscillator rate in MHz.
`define HSC_CLK_MHZ        100
// Default bus idle time in clock cycles.
`define HSC_IDLE_CYCLES    5000
// Cycles after a release in which the other side may not claim a channel.
`define HSC_TURN_GUARD     4

// ----------------------------------------------------------------------------
// Channel indices
// ----------------------------------------------------------------------------

// Clock channel index.
`define HSC_CH_CLK         0
// Data channel index.
`define HSC_CH_DAT         1
// Interrupt channel index.
`define HSC_CH_IRQ         2
// Number of channels.
`define HSC_NCH            3

`endif

// File: src/hsc_pkg.sv
package hsc_pkg;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------

  // Hot-swap sequencer states.
  typedef enum logic [2:0] {
    HSC_POWERUP,
    HSC_REF_WAIT,
    HSC_TERM_CHECK,
    HSC_TERM_WAIT,
    HSC_ARMED,
    HSC_CONNECTED
  } hsc_state_type;

  // One differential pair as seen by the comparators.
  typedef struct packed {
    logic plus_high;
    logic minus_high;
    logic minus_below_90;
    logic plus_above_10;
  } hsc_pair_type;

  // Drive of one line: enable drives the line to the level in out.
  typedef struct packed {
    logic out;
    logic oe;
  } hsc_drive_type;

endpackage

// File: tb/hsc_ctrl_chk.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Port checker for the hot-swap controller
// ----------------------------------------------------------------------------
module hsc_ctrl_chk
  import hsc_pkg::*;
#(
  parameter int REF_CYCLES  = 100000,
  parameter int TERM_CYCLES = 1000000
) (
  input wire logic                core_clk_in,
  input wire logic                arst_n_in,
  input wire logic                supply_good_in,
  input wire logic                enable_in,
  input wire logic                enable_driven_in,
  input wire logic [2:0]          se_line_in,
  input wire hsc_pair_type [2:0]  pair_in,
  input wire hsc_drive_type [2:0] se_drive_out,
  input wire hsc_drive_type [2:0] plus_drive_out,
  input wire hsc_drive_type [2:0] minus_drive_out,
  input wire logic                plug_in_detect_n_out,
  input wire logic                plug_in_detect_n_oe_out,
  input wire logic                ready_n_out,
  input wire logic                ready_n_oe_out
);
  logic       en_eff;
  logic       term_ok;
  logic [2:0] se_oe;
  logic [2:0] pm_oe;
  int         tcnt;
  int         scnt;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // An undriven enable pin reads high through its pull-up.
  assign en_eff  = enable_in | ~enable_driven_in;
  assign term_ok = pair_in[0].minus_below_90 & pair_in[0].plus_above_10 &
                   pair_in[1].minus_below_90 & pair_in[1].plus_above_10;
  // Gather the drive enables per channel.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      se_oe[i] = se_drive_out[i].oe;
      pm_oe[i] = plus_drive_out[i].oe | minus_drive_out[i].oe;
    end
  end
  // Ages of the supply and of the terminations, both raw, so they are
  // never younger than what the design sees behind its synchronisers.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tcnt <= 0;
      scnt <= 0;
    end else begin
      tcnt <= term_ok ? tcnt + 1 : 0;
      scnt <= supply_good_in ? scnt + 1 : 0;
    end
  end
  a_detect_after_timers: assert property ($rose(plug_in_detect_n_oe_out) |->
    scnt >= REF_CYCLES + TERM_CYCLES && tcnt >= TERM_CYCLES) else $error("detect before timers");
  a_ready_needs_detect: assert property (ready_n_oe_out |-> plug_in_detect_n_oe_out)
    else $error("ready without detect");
  a_ready_needs_en: assert property ((!en_eff)[*5] |-> !ready_n_oe_out)
    else $error("ready while disabled");
  a_no_link_disabled: assert property ((!en_eff)[*5] |-> se_oe == 3'h0 && pm_oe == 3'h0)
    else $error("link while disabled");
  a_off_unpowered: assert property ((!supply_good_in)[*5] |->
    !plug_in_detect_n_oe_out && !ready_n_oe_out && se_oe == 3'h0 && pm_oe == 3'h0) else $error("drive unpowered");
  a_link_when_armed: assert property ((se_oe != 3'h0 || pm_oe != 3'h0) |-> plug_in_detect_n_oe_out)
    else $error("link before armed");
  a_status_low_level: assert property (!plug_in_detect_n_out && !ready_n_out)
    else $error("status pin level");
  for (genvar i = 0; i < 3; i++) begin : g_ch
    a_one_way_only: assert property (!(se_oe[i] && pm_oe[i]))
      else $error("channel drives both sides");
    a_pair_sense: assert property (plus_drive_out[i].oe |->
      minus_drive_out[i].oe && !plus_drive_out[i].out && minus_drive_out[i].out) else $error("pair polarity");
    a_se_low_level: assert property (!se_drive_out[i].out)
      else $error("line drive level");
    a_se_to_pair: assert property ($fell(se_line_in[i]) && ready_n_oe_out && !se_oe[i] &&
      pair_in[i].plus_high |-> ##[1:5] plus_drive_out[i].oe) else $error("low not forwarded");
  end
endmodule // hsc_ctrl_chk

bind hsc_ctrl hsc_ctrl_chk #(.REF_CYCLES(REF_CYCLES), .TERM_CYCLES(TERM_CYCLES)) u_chk (.*);

// File: tb/hsc_far_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Far side of the bridge: pair bias, remote nodes, card devices
// ----------------------------------------------------------------------------
module hsc_far_model
  import hsc_pkg::*;
(
  input  wire logic               term_ok_in,
  input  wire logic [2:0]         far_low_in,
  input  wire logic [2:0]         dev_low_in,
  input  wire hsc_drive_type [2:0] se_drive_in,
  input  wire hsc_drive_type [2:0] plus_drive_in,
  input  wire hsc_drive_type [2:0] minus_drive_in,
  output hsc_pair_type [2:0]      pair_out,
  output logic [2:0]              se_line_out
);
  // A pair rests with plus above minus unless some node sinks it; without
  // termination there is no bias, so neither comparator sees a valid level.
  always_comb begin
    logic low;
    low = 1'b0;
    for (int i = 0; i < 3; i++) begin
      low = far_low_in[i] | plus_drive_in[i].oe | minus_drive_in[i].oe;
      pair_out[i].plus_high      = term_ok_in & ~low;
      pair_out[i].minus_high     = term_ok_in & low;
      pair_out[i].minus_below_90 = term_ok_in;
      pair_out[i].plus_above_10  = term_ok_in;
      se_line_out[i] = ~(se_drive_in[i].oe | dev_low_in[i]);   // Wired-OR with pull-up.
    end
  end
endmodule // hsc_far_model

// File: tb/testbench.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Self-checking bench: notes of expected drive states, checked on change
// ----------------------------------------------------------------------------
module testbench;
  import hsc_pkg::*;
  localparam logic [7:0] PID = 8'h40;
  localparam logic [7:0] RDY = 8'hc0;
  logic core_clk_in = 1'b0;
  logic arst_n_in, supply_good_in, enable_in, enable_driven_in, term_ok;
  logic [2:0] far_low, dev_low, se_line_in;
  hsc_pair_type [2:0] pair_in;
  hsc_drive_type [2:0] se_drive_out, plus_drive_out, minus_drive_out;
  logic plug_in_detect_n_out, plug_in_detect_n_oe_out, ready_n_out, ready_n_oe_out;
  logic [7:0] obs;
  logic [7:0] last_obs = 8'h00;
  logic [7:0] notes[$];
  int failures = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h9b4c_b73d;
  always #5 core_clk_in = ~core_clk_in;
  hsc_ctrl #(.REF_CYCLES(20), .TERM_CYCLES(50), .IDLE_CYCLES(8)) DUT (.*);
  hsc_far_model u_far (.term_ok_in(term_ok), .far_low_in(far_low), .dev_low_in(dev_low),
    .se_drive_in(se_drive_out), .plus_drive_in(plus_drive_out), .minus_drive_in(minus_drive_out),
    .pair_out(pair_in), .se_line_out(se_line_in));
  assign obs = {ready_n_oe_out, plug_in_detect_n_oe_out, plus_drive_out[2].oe, plus_drive_out[1].oe,
                plus_drive_out[0].oe, se_drive_out[2].oe, se_drive_out[1].oe, se_drive_out[0].oe};
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check_obs(input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch drives expected %h seen %h", exp, got);
    end
  endtask
  // Any change of the drives settles the oldest note; a change with no
  // note pending is compared against the unchanged state and so fails.
  always @(posedge core_clk_in) begin
    if (arst_n_in !== 1'b1) last_obs <= 8'h00;
    else if (obs !== last_obs) begin
      last_obs <= obs;
      check_obs(notes.size() != 0 ? notes.pop_front() : last_obs, obs);
    end
  end
  task automatic expect_obs(input logic [7:0] v, input int lim);
    int k;
    k = 0;
    notes.push_back(v);
    while (notes.size() != 0 && k < lim) begin
      @(posedge core_clk_in);
      k++;
    end
    if (notes.size() != 0) begin
      notes.delete();
      check_obs(v, ~obs);
    end
  endtask
  // One side sinks a channel for a random time; the bridge must follow.
  task automatic transfer(input int ch, input bit far);
    int n;
    seed = xs(seed);
    n = 2 + seed[2:0];
    @(posedge core_clk_in);
    if (far) far_low[ch] <= 1'b1;
    else dev_low[ch] <= 1'b1;
    expect_obs(RDY | (far ? 8'h01 << ch : 8'h08 << ch), 20);
    repeat (n) @(posedge core_clk_in);
    far_low[ch] <= 1'b0;
    dev_low[ch] <= 1'b0;
    expect_obs(RDY, 20);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Power-up with the enable pin left floating, so its pull-up enables.
  initial begin
    arst_n_in <= 1'b0;
    supply_good_in <= 1'b1;
    enable_in <= 1'b0;
    enable_driven_in <= 1'b0;
    term_ok <= 1'b1;
    far_low <= 3'h0;
    dev_low <= 3'h0;
    repeat (12) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    expect_obs(PID, 200);
    expect_obs(RDY, 50);
    $display("test power-up done");
    for (int ch = 0; ch < 3; ch++) begin
      transfer(ch, 1'b0);
      transfer(ch, 1'b1);
    end
    $display("test transfers done");
    enable_driven_in <= 1'b1;
    expect_obs(PID, 20);
    dev_low[1] <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    dev_low[1] <= 1'b0;
    far_low[1] <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    far_low[1] <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    enable_in <= 1'b1;
    expect_obs(RDY, 40);
    $display("test enable done");
    term_ok <= 1'b0;
    expect_obs(8'h00, 20);
    term_ok <= 1'b1;
    expect_obs(PID, 200);
    expect_obs(RDY, 50);
    $display("test termination done");
    seed = xs(seed);
    supply_good_in <= 1'b0;
    expect_obs(8'h00, 20);
    repeat (seed[3:0]) @(posedge core_clk_in);
    supply_good_in <= 1'b1;
    expect_obs(PID, 200);
    expect_obs(RDY, 50);
    $display("test supply done");
    arst_n_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    expect_obs(PID, 200);
    expect_obs(RDY, 50);
    // The third channel is now left unused, so its card pin is tied low.
    dev_low[2] <= 1'b1;
    expect_obs(RDY | 8'h20, 20);
    $display("test reset done");
    wrap_up;
  end
  // The tests need about 500 cycles; over thirty times that means a hang.
  initial begin
    repeat (20000) @(posedge core_clk_in);
    failures++;
    $display("watchdog expired");
    wrap_up;
  end
endmodule // testbench
